// [serial_irq_logic.sv]
// event flags, interrupt enables and interrupt outputs of the serial port
//
// Our own choice: the strobed register port.
`timescale 1ns/1ns
`include "serial_irq_consts.svh"
module serial_irq_logic
(
    input wire logic clock,
    input wire logic reset,
    // register port
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    output logic [31:0] read_data_q,
    // events from the transmitter, receiver and line logic, one-cycle pulses
    input wire logic tx_moved,
    input wire logic tx_done_evt,
    input wire logic guard_done_evt,
    input wire logic cts_change_evt,
    input wire logic rx_word_evt,
    input wire logic overrun_evt,
    input wire logic idle_evt,
    input wire logic parity_evt,
    input wire logic noise_evt,
    input wire logic framing_evt,
    input wire logic break_evt,
    input wire logic match_evt,
    input wire logic timeout_evt,
    input wire logic block_end_evt,
    input wire logic wakeup_evt,
    input wire logic underrun_evt,
    // queue fill levels and mode
    input wire logic [3:0] tx_queue_count,
    input wire logic [3:0] rx_queue_count,
    input wire logic stop_mode,
    input wire logic [8:0] rx_word,
    // toward the data path
    output logic [31:0] ctrl_one_q,
    output logic [15:0] ctrl_three_q,
    output logic [8:0] tx_word_q,
    output logic tx_write_pulse_q,
    output logic rx_read_pulse_q,
    output logic tx_flush_pulse_q,
    output logic rx_flush_pulse_q,
    // toward the interrupt and power controller
    output logic serial_irq,
    output logic wake_irq
);
    // ==========================================================
    // register port decode
    serial_irq_pkg::reg_sel_t sel;
    logic wr_ctrl_one;
    logic wr_ctrl_three;
    logic wr_request;
    logic wr_clear;
    logic wr_tx_data;
    logic rd_rx_data;
    logic tx_flush;
    logic rx_flush;

    // one address per register; anything else selects nothing
    // so unmapped reads return zero and unmapped writes fall away
    always_comb
    begin
        case (address)
            `OFS_CTRL_ONE: sel = serial_irq_pkg::SEL_CTRL_ONE;
            `OFS_CTRL_THREE: sel = serial_irq_pkg::SEL_CTRL_THREE;
            `OFS_REQUEST: sel = serial_irq_pkg::SEL_REQUEST;
            `OFS_STATUS: sel = serial_irq_pkg::SEL_STATUS;
            `OFS_CLEAR: sel = serial_irq_pkg::SEL_CLEAR;
            `OFS_RX_DATA: sel = serial_irq_pkg::SEL_RX_DATA;
            `OFS_TX_DATA: sel = serial_irq_pkg::SEL_TX_DATA;
            default: sel = serial_irq_pkg::SEL_NONE;
        endcase
    end

    // write and read side effects of the current strobe
    assign wr_ctrl_one = write_strobe && (sel == serial_irq_pkg::SEL_CTRL_ONE);
    assign wr_ctrl_three = write_strobe && (sel == serial_irq_pkg::SEL_CTRL_THREE);
    assign wr_request = write_strobe && (sel == serial_irq_pkg::SEL_REQUEST);
    assign wr_clear = write_strobe && (sel == serial_irq_pkg::SEL_CLEAR);
    assign wr_tx_data = write_strobe && (sel == serial_irq_pkg::SEL_TX_DATA);
    assign rd_rx_data = read_strobe && (sel == serial_irq_pkg::SEL_RX_DATA);
    assign tx_flush = wr_request && write_data[`REQ_TX_FLUSH];
    assign rx_flush = wr_request && write_data[`REQ_RX_FLUSH];

    // ==========================================================
    // control registers
    logic port_on;
    logic queue_on;
    logic [31:0] locked;

    assign port_on = ctrl_one_q[`C1_ENABLE];
    assign queue_on = ctrl_one_q[`C1_QUEUE_MODE];
    assign locked = `CTRL_ONE_LOCKED;

    // framing and queue-mode fields only change while the port is off,
    // so the data path never sees its format switch mid-character;
    // the enable bit stays writable so the port can always be stopped
    always_ff @(posedge clock)
    begin
        if (reset)
            ctrl_one_q <= `CTRL_ONE_RESET;
        else if (wr_ctrl_one && port_on)
            ctrl_one_q <= (ctrl_one_q & locked) | (write_data & ~locked);
        else if (wr_ctrl_one)
            ctrl_one_q <= write_data;
    end

    // enables and thresholds of the events without room in the first register
    always_ff @(posedge clock)
    begin
        if (reset)
            ctrl_three_q <= `CTRL_THREE_RESET;
        else if (wr_ctrl_three)
            ctrl_three_q <= write_data[15:0];
    end

    // ==========================================================
    // strobes toward the data path, registered so the outputs come from flops
    // they arrive one cycle after the bus strobe
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            tx_write_pulse_q <= 1'b0;
            rx_read_pulse_q <= 1'b0;
            tx_flush_pulse_q <= 1'b0;
            rx_flush_pulse_q <= 1'b0;
        end
        else
        begin
            tx_write_pulse_q <= wr_tx_data;
            rx_read_pulse_q <= rd_rx_data;
            tx_flush_pulse_q <= tx_flush;
            rx_flush_pulse_q <= rx_flush;
        end
    end

    // transmit word held for the shifter
    always_ff @(posedge clock)
    begin
        if (reset)
            tx_word_q <= 9'h000;
        else if (wr_tx_data)
            tx_word_q <= write_data[8:0];
    end

    // ==========================================================
    // flag set and clear terms
    serial_irq_pkg::flag_vec_t set_v;
    serial_irq_pkg::flag_vec_t clr_v;
    serial_irq_pkg::flag_vec_t flag_v;
    serial_irq_pkg::flag_vec_t sw_mask;
    serial_irq_pkg::level_t tx_thresh;
    serial_irq_pkg::level_t rx_thresh;
    logic tx_full;
    logic rx_full;

    assign sw_mask = `SW_CLEAR_MASK;
    assign tx_thresh = ctrl_three_q[11:8];
    assign rx_thresh = ctrl_three_q[15:12];
    assign tx_full = (tx_queue_count == `QUEUE_DEPTH);
    assign rx_full = (rx_queue_count == `QUEUE_DEPTH);

    // events set flags only while the port runs; queue flags only in queue mode
    always_comb
    begin
        set_v = '0;
        set_v[`F_PARITY] = parity_evt;
        set_v[`F_FRAMING] = framing_evt;
        set_v[`F_NOISE] = noise_evt;
        set_v[`F_OVERRUN] = overrun_evt;
        set_v[`F_IDLE] = idle_evt;
        set_v[`F_RX_READY] = rx_word_evt;
        set_v[`F_DONE] = tx_done_evt;
        set_v[`F_TX_EMPTY] = tx_moved;
        set_v[`F_BREAK] = break_evt;
        set_v[`F_CTS] = cts_change_evt;
        set_v[`F_TIMEOUT] = timeout_evt;
        set_v[`F_BLOCK_END] = block_end_evt;
        set_v[`F_UNDERRUN] = underrun_evt;
        set_v[`F_MATCH] = match_evt;
        set_v[`F_GUARD] = guard_done_evt;
        set_v[`F_WAKEUP] = wakeup_evt;
        set_v[`F_TXQ_SPACE] = queue_on && !tx_full;
        set_v[`F_TXQ_EMPTY] = queue_on && (tx_queue_count == 4'h0);
        set_v[`F_TXQ_LEVEL] = queue_on && (tx_queue_count >= tx_thresh);
        set_v[`F_RXQ_NONEMPTY] = queue_on && (rx_queue_count != 4'h0);
        // the last word sits in the data register, so the queue plus it is depth plus one
        set_v[`F_RXQ_FULL] = queue_on && rx_full && !stop_mode && flag_v[`F_RX_READY];
        set_v[`F_RXQ_LEVEL] = queue_on && (rx_queue_count >= rx_thresh);
        // a stopped port must not set what it is clearing
        set_v = set_v & {`FLAG_COUNT{port_on}};
    end

    // clears from software, from the data registers and from the queue levels
    always_comb
    begin
        clr_v = '0;
        if (wr_clear)
            clr_v = write_data[21:0] & sw_mask;
        clr_v[`F_TX_EMPTY] = wr_tx_data;
        clr_v[`F_DONE] = clr_v[`F_DONE] | wr_tx_data;
        clr_v[`F_GUARD] = clr_v[`F_GUARD] | wr_tx_data;
        clr_v[`F_RX_READY] = rd_rx_data | rx_flush;
        clr_v[`F_TXQ_SPACE] = tx_full || !queue_on;
        clr_v[`F_TXQ_EMPTY] = (tx_queue_count != 4'h0) || tx_flush || !queue_on;
        clr_v[`F_TXQ_LEVEL] = (tx_queue_count < tx_thresh) || !queue_on;
        clr_v[`F_RXQ_NONEMPTY] = (rx_queue_count == 4'h0) || rx_flush || !queue_on;
        clr_v[`F_RXQ_FULL] = !rx_full || !queue_on;
        clr_v[`F_RXQ_LEVEL] = (rx_queue_count < rx_thresh) || !queue_on;
        // a stopped port drops every flag but keeps its configuration
        if (!port_on)
            clr_v = '1;
    end

    // ==========================================================
    // the flags themselves, one sticky cell each
    // one cell type keeps set-beats-clear in a single place
    genvar i;
    generate
        for (i = 0; i < `FLAG_COUNT; i = i + 1)
        begin : g_flag
            event_flag #(
                .RESET_VALUE(1'b0)
            ) u_flag (
                .clock(clock),
                .reset(reset),
                .set(set_v[i]),
                .clear(clr_v[i]),
                .flag_q(flag_v[i])
            );
        end
    endgenerate

    // ==========================================================
    // enables per flag
    serial_irq_pkg::flag_vec_t en_v;
    logic err_en;

    assign err_en = ctrl_three_q[`C3_ERR_EN];

    // the first register keeps one layout in both queue modes, so a shared bit
    // enables the data-register flag and its queue counterpart together;
    // overrun also rides on the receive enable
    always_comb
    begin
        en_v = '0;
        en_v[`F_PARITY] = ctrl_one_q[`C1_PARITY_EN];
        en_v[`F_FRAMING] = err_en;
        en_v[`F_NOISE] = err_en;
        en_v[`F_OVERRUN] = ctrl_one_q[`C1_RX_EN] | err_en;
        en_v[`F_IDLE] = ctrl_one_q[`C1_IDLE_EN];
        en_v[`F_RX_READY] = ctrl_one_q[`C1_RX_EN];
        en_v[`F_DONE] = ctrl_one_q[`C1_DONE_EN];
        en_v[`F_TX_EMPTY] = ctrl_one_q[`C1_TX_EN];
        en_v[`F_BREAK] = ctrl_three_q[`C3_BREAK_EN];
        en_v[`F_CTS] = ctrl_three_q[`C3_CTS_EN];
        en_v[`F_TIMEOUT] = ctrl_one_q[`C1_TIMEOUT_EN];
        en_v[`F_BLOCK_END] = ctrl_one_q[`C1_BLOCK_EN];
        en_v[`F_UNDERRUN] = err_en;
        en_v[`F_MATCH] = ctrl_one_q[`C1_MATCH_EN];
        en_v[`F_GUARD] = ctrl_three_q[`C3_GUARD_EN];
        en_v[`F_WAKEUP] = ctrl_three_q[`C3_WAKEUP_EN];
        en_v[`F_TXQ_SPACE] = ctrl_one_q[`C1_TX_EN];
        en_v[`F_TXQ_EMPTY] = ctrl_one_q[`C1_TXQ_EMPTY_EN];
        en_v[`F_TXQ_LEVEL] = ctrl_three_q[`C3_TXQ_LEVEL_EN];
        en_v[`F_RXQ_NONEMPTY] = ctrl_one_q[`C1_RX_EN];
        en_v[`F_RXQ_FULL] = ctrl_one_q[`C1_RXQ_FULL_EN];
        en_v[`F_RXQ_LEVEL] = ctrl_three_q[`C3_RXQ_LEVEL_EN];
    end

    // ==========================================================
    // interrupt merge
    flag_bus_if fbus ();
    logic stop_hit;

    // in stop mode the data register is not clocked: a full queue alone
    // raises the full interrupt, and the flag stays clear
    // limitation: the line drops once the queue is no longer full
    assign stop_hit = port_on && queue_on && stop_mode && rx_full
        && ctrl_one_q[`C1_RXQ_FULL_EN];
    assign fbus.flags = flag_v;
    assign fbus.enables = en_v;
    assign fbus.lowpower_en = ctrl_one_q[`C1_LOWPOWER];
    assign fbus.stop_full_hit = stop_hit;

    irq_merge u_merge (
        .clock(clock),
        .reset(reset),
        .bus(fbus.merge)
    );

    // both lines come straight from the merge flip-flops
    assign serial_irq = fbus.serial_irq;
    assign wake_irq = fbus.wake_irq;

    // ==========================================================
    // read data, valid in the cycle after the read strobe only
    // zero otherwise, so stale data never looks fresh
    always_ff @(posedge clock)
    begin
        if (reset)
            read_data_q <= 32'h0000_0000;
        else if (read_strobe)
        begin
            case (sel)
                serial_irq_pkg::SEL_CTRL_ONE: read_data_q <= ctrl_one_q;
                serial_irq_pkg::SEL_CTRL_THREE: read_data_q <= {16'h0000, ctrl_three_q};
                serial_irq_pkg::SEL_STATUS: read_data_q <= {10'h000, flag_v};
                serial_irq_pkg::SEL_RX_DATA: read_data_q <= {23'h00_0000, rx_word};
                default: read_data_q <= 32'h0000_0000;
            endcase
        end
        else
            read_data_q <= 32'h0000_0000;
    end
endmodule

// [serial_irq_consts.svh]
// offsets, field positions, reset values and masks of the serial event and interrupt logic
`ifndef SERIAL_IRQ_CONSTS_SVH
`define SERIAL_IRQ_CONSTS_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_THREE 8'h08
`define OFS_REQUEST 8'h18
`define OFS_STATUS 8'h1c
`define OFS_CLEAR 8'h20
`define OFS_RX_DATA 8'h24
`define OFS_TX_DATA 8'h28

// ==========================================================
// reset values and write masks
`define CTRL_ONE_RESET 32'h0000_0000
`define CTRL_THREE_RESET 16'h0000
`define CTRL_ONE_LOCKED 32'h33ff_9e00
`define SW_CLEAR_MASK 22'h00_ff5f
`define WAKE_CAPABLE 22'h3e_8020

// ==========================================================
// flag positions in the status and clear registers
`define FLAG_COUNT 22
`define F_PARITY 0
`define F_FRAMING 1
`define F_NOISE 2
`define F_OVERRUN 3
`define F_IDLE 4
`define F_RX_READY 5
`define F_DONE 6
`define F_TX_EMPTY 7
`define F_BREAK 8
`define F_CTS 9
`define F_TIMEOUT 10
`define F_BLOCK_END 11
`define F_UNDERRUN 12
`define F_MATCH 13
`define F_GUARD 14
`define F_WAKEUP 15
`define F_TXQ_SPACE 16
`define F_TXQ_EMPTY 17
`define F_TXQ_LEVEL 18
`define F_RXQ_NONEMPTY 19
`define F_RXQ_FULL 20
`define F_RXQ_LEVEL 21

// ==========================================================
// control field positions
`define C1_ENABLE 0
`define C1_LOWPOWER 1
`define C1_IDLE_EN 4
`define C1_RX_EN 5
`define C1_DONE_EN 6
`define C1_TX_EN 7
`define C1_PARITY_EN 8
`define C1_MATCH_EN 14
`define C1_TIMEOUT_EN 26
`define C1_BLOCK_EN 27
`define C1_QUEUE_MODE 29
`define C1_TXQ_EMPTY_EN 30
`define C1_RXQ_FULL_EN 31
`define C3_ERR_EN 0
`define C3_BREAK_EN 1
`define C3_CTS_EN 2
`define C3_GUARD_EN 3
`define C3_WAKEUP_EN 4
`define C3_TXQ_LEVEL_EN 5
`define C3_RXQ_LEVEL_EN 6
`define REQ_RX_FLUSH 3
`define REQ_TX_FLUSH 4
`define QUEUE_DEPTH 4'h8

`endif

// [serial_irq_pkg.sv]
// types shared by the serial event and interrupt logic
package serial_irq_pkg;
    typedef logic [21:0] flag_vec_t;
    typedef logic [3:0] level_t;
    typedef enum {SEL_CTRL_ONE, SEL_CTRL_THREE, SEL_REQUEST, SEL_STATUS, SEL_CLEAR,
        SEL_RX_DATA, SEL_TX_DATA, SEL_NONE} reg_sel_t;
endpackage

// [flag_bus_if.sv]
// flags and enables passed from the register side to the interrupt merge
`timescale 1ns/1ns
interface flag_bus_if;
    logic [21:0] flags;
    logic [21:0] enables;
    logic lowpower_en;
    logic stop_full_hit;
    logic serial_irq;
    logic wake_irq;
    modport source (output flags, enables, lowpower_en, stop_full_hit,
        input serial_irq, wake_irq);
    modport merge (input flags, enables, lowpower_en, stop_full_hit,
        output serial_irq, wake_irq);
endinterface

// [event_flag.sv]
// one sticky event flag where a set beats a clear in the same cycle
`timescale 1ns/1ns
module event_flag
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic set,
    input wire logic clear,
    output logic flag_q
);
    // set first, so an event in the clearing cycle is kept
    always_ff @(posedge clock)
    begin
        if (reset)
            flag_q <= RESET_VALUE;
        else if (set)
            flag_q <= 1'b1;
        else if (clear)
            flag_q <= 1'b0;
    end
endmodule

// [irq_merge.sv]
// gates the flags with their enables onto the two registered interrupt lines
`timescale 1ns/1ns
`include "serial_irq_consts.svh"
module irq_merge
(
    input wire logic clock,
    input wire logic reset,
    flag_bus_if.merge bus
);
    logic [21:0] live;
    logic [21:0] wake_mask;

    // a flag counts only while its enable is set
    assign live = bus.flags & bus.enables;
    assign wake_mask = `WAKE_CAPABLE;

    // general line stays up while any enabled flag stays set
    always_ff @(posedge clock)
    begin
        if (reset)
            bus.serial_irq <= 1'b0;
        else
            bus.serial_irq <= (|live) | bus.stop_full_hit;
    end

    // wake line only from the wake-capable subset, and only when low power wake is on
    always_ff @(posedge clock)
    begin
        if (reset)
            bus.wake_irq <= 1'b0;
        else
            bus.wake_irq <= bus.lowpower_en & ((|(live & wake_mask)) | bus.stop_full_hit);
    end
endmodule

// [serial_irq_checker.sv]
// port assertions of the serial event and interrupt logic
`timescale 1ns/1ns
`include "serial_irq_consts.svh"
module serial_irq_checker
(
    input wire logic clock,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic [31:0] write_data,
    input wire logic write_strobe,
    input wire logic read_strobe,
    input wire logic [31:0] read_data_q,
    input wire logic parity_evt,
    input wire logic noise_evt,
    input wire logic wakeup_evt,
    input wire logic [8:0] rx_word,
    input wire logic [31:0] ctrl_one_q,
    input wire logic [15:0] ctrl_three_q,
    input wire logic [8:0] tx_word_q,
    input wire logic tx_write_pulse_q,
    input wire logic rx_read_pulse_q,
    input wire logic tx_flush_pulse_q,
    input wire logic rx_flush_pulse_q,
    input wire logic serial_irq,
    input wire logic wake_irq
);
    // ========
    // one clock domain, so clocking and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // ========
    // register port
    a_read_idle_zero: assert property (!$past(read_strobe) |-> read_data_q == 32'h0)
        else $error("read data not zero outside a read");
    a_rx_data_read: assert property (read_strobe && address == `OFS_RX_DATA |=>
        rx_read_pulse_q && read_data_q == {23'h0, $past(rx_word)})
        else $error("receive data read wrong");
    a_tx_data_write: assert property (write_strobe && address == `OFS_TX_DATA |=>
        tx_write_pulse_q && tx_word_q == $past(write_data[8:0]))
        else $error("transmit data write wrong");
    a_flush_request: assert property (write_strobe && address == `OFS_REQUEST |=>
        tx_flush_pulse_q == $past(write_data[`REQ_TX_FLUSH])
        && rx_flush_pulse_q == $past(write_data[`REQ_RX_FLUSH]))
        else $error("flush pulse wrong");
    a_ctrl_free_write: assert property (write_strobe && address == `OFS_CTRL_ONE
        && !ctrl_one_q[0] |=> ctrl_one_q == $past(write_data))
        else $error("control write while off lost");
    a_ctrl_mode_lock: assert property (write_strobe && address == `OFS_CTRL_ONE
        && ctrl_one_q[0] |=> (ctrl_one_q & `CTRL_ONE_LOCKED)
        == ($past(ctrl_one_q) & `CTRL_ONE_LOCKED))
        else $error("locked control field changed");

    // ========
    // interrupt lines, two edges after the event
    a_parity_irq_up: assert property (parity_evt && ctrl_one_q[0] ##1
        ctrl_one_q[`C1_PARITY_EN] |=> serial_irq)
        else $error("parity event raised no interrupt");
    a_noise_irq_up: assert property (noise_evt && ctrl_one_q[0] ##1
        ctrl_three_q[`C3_ERR_EN] |=> serial_irq)
        else $error("noise event raised no interrupt");
    a_wake_both_up: assert property (wakeup_evt && ctrl_one_q[0] ##1
        ctrl_three_q[`C3_WAKEUP_EN] && ctrl_one_q[`C1_LOWPOWER] |=> serial_irq && wake_irq)
        else $error("wakeup event missed a line");
    a_wake_gated: assert property (wake_irq |-> $past(ctrl_one_q[`C1_LOWPOWER]))
        else $error("wake line without low-power enable");
    a_off_quiet: assert property (!ctrl_one_q[0] [*2] |=> !serial_irq && !wake_irq)
        else $error("interrupt while port off");
endmodule

bind serial_irq_logic serial_irq_checker i_chk (.clock, .reset, .address, .write_data,
    .write_strobe, .read_strobe, .read_data_q, .parity_evt, .noise_evt, .wakeup_evt,
    .rx_word, .ctrl_one_q, .ctrl_three_q, .tx_word_q, .tx_write_pulse_q, .rx_read_pulse_q,
    .tx_flush_pulse_q, .rx_flush_pulse_q, .serial_irq, .wake_irq);

// [irq_sink.sv]
// model of the interrupt controller that takes the two request lines
`timescale 1ns/1ns
module irq_sink
(
    input wire logic clock,
    input wire logic reset,
    input wire logic serial_irq,
    input wire logic wake_irq,
    output logic [7:0] irq_taken_q,
    output logic [7:0] wake_taken_q
);
    logic [1:0] seen_q;
    // ========
    // level lines: each rise is taken once, as an edge-sensitive controller would
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            seen_q <= 2'b00;
            irq_taken_q <= 8'h00;
            wake_taken_q <= 8'h00;
        end
        else
        begin
            seen_q <= {serial_irq, wake_irq};
            if (serial_irq && !seen_q[1])
                irq_taken_q <= irq_taken_q + 8'h01;
            if (wake_irq && !seen_q[0])
                wake_taken_q <= wake_taken_q + 8'h01;
        end
    end
endmodule

// [tb.sv]
// self-checking testbench of the serial event and interrupt logic
`timescale 1ns/1ns
`include "serial_irq_consts.svh"
module tb;
    logic clock;
    logic reset;
    logic [7:0] address;
    logic [31:0] write_data;
    logic write_strobe;
    logic read_strobe;
    logic [31:0] read_data_q;
    logic [15:0] ev;
    logic [3:0] tx_queue_count;
    logic [3:0] rx_queue_count;
    logic stop_mode;
    logic [8:0] rx_word;
    logic [8:0] tx_word_q;
    logic serial_irq;
    logic wake_irq;
    logic [7:0] wake_taken_q;
    logic [7:0] irq_taken_q;
    logic [31:0] got;
    int fails;
    int tests_run;

    // ========
    // design and interrupt controller; events travel as one vector, bit i per source
    serial_irq_logic i_dut (.clock(clock), .reset(reset), .address(address),
        .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe),
        .read_data_q(read_data_q), .tx_moved(ev[0]), .tx_done_evt(ev[1]),
        .guard_done_evt(ev[2]), .cts_change_evt(ev[3]), .rx_word_evt(ev[4]),
        .overrun_evt(ev[5]), .idle_evt(ev[6]), .parity_evt(ev[7]), .noise_evt(ev[8]),
        .framing_evt(ev[9]), .break_evt(ev[10]), .match_evt(ev[11]), .timeout_evt(ev[12]),
        .block_end_evt(ev[13]), .wakeup_evt(ev[14]), .underrun_evt(ev[15]),
        .tx_queue_count(tx_queue_count), .rx_queue_count(rx_queue_count),
        .stop_mode(stop_mode), .rx_word(rx_word), .ctrl_one_q(), .ctrl_three_q(),
        .tx_word_q(tx_word_q), .tx_write_pulse_q(), .rx_read_pulse_q(),
        .tx_flush_pulse_q(), .rx_flush_pulse_q(), .serial_irq(serial_irq),
        .wake_irq(wake_irq));
    irq_sink i_sink (.clock(clock), .reset(reset), .serial_irq(serial_irq),
        .wake_irq(wake_irq), .irq_taken_q(irq_taken_q), .wake_taken_q(wake_taken_q));

    // ========
    // bus cycles and comparisons
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
        write_strobe <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so take them there
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #1;
        got = read_data_q;
    endtask
    task automatic fire(input logic [15:0] m);
        @(posedge clock);
        ev <= m;
        @(posedge clock);
        ev <= 16'h0;
    endtask
    // lines follow the flag by one edge; look just after it
    task automatic settle();
        @(posedge clock);
        #1;
    endtask
    task automatic chk_irq(input logic [1:0] e);
        check({30'h0, serial_irq, wake_irq}, {30'h0, e});
    endtask
    task automatic levels(input logic [3:0] t, input logic [3:0] r, input logic s);
        @(posedge clock);
        tx_queue_count <= t;
        rx_queue_count <= r;
        stop_mode <= s;
    endtask

    // ========
    // scenarios
    task automatic s_regs();
        rd(`OFS_CTRL_ONE);
        check(got, `CTRL_ONE_RESET);
        rd(8'h40);
        check(got, 32'h0);
        wr(`OFS_CTRL_ONE, 32'h2000_0000);
        rd(`OFS_CTRL_ONE);
        check(got, 32'h2000_0000);
        wr(`OFS_CTRL_ONE, 32'h0000_0001);
        wr(`OFS_CTRL_ONE, 32'h2000_0003);
        rd(`OFS_CTRL_ONE);
        check(got, 32'h0000_0003);
    endtask
    // every software-cleared flag but wakeup: enable alone, raise, clear by its own bit
    task automatic s_events();
        int evi[13] = '{7, 6, 5, 1, 11, 12, 13, 3, 10, 8, 9, 15, 2};
        int fl[13] = '{0, 4, 3, 6, 13, 10, 11, 9, 8, 2, 1, 12, 14};
        int en[13] = '{8, 4, 5, 6, 14, 26, 27, 34, 33, 32, 32, 32, 35};
        logic [63:0] e;
        for (int i = 0; i < 13; i++)
        begin
            e = 64'h1 << en[i];
            wr(`OFS_CTRL_ONE, e[31:0] | 32'h3);
            wr(`OFS_CTRL_THREE, {16'h0, e[47:32]});
            fire(16'h1 << evi[i]);
            settle();
            chk_irq(2'b10);
            rd(`OFS_STATUS);
            check(got, 32'h1 << fl[i]);
            wr(`OFS_CLEAR, 32'h1 << fl[i]);
            settle();
            chk_irq(2'b00);
        end
    endtask
    task automatic s_tx();
        wr(`OFS_CTRL_ONE, 32'h0000_00c3);
        wr(`OFS_CTRL_THREE, 32'h0000_0008);
        fire(16'h0007);
        settle();
        chk_irq(2'b10);
        rd(`OFS_STATUS);
        check(got, 32'h0000_40c0);
        wr(`OFS_TX_DATA, 32'h0000_01a5);
        settle();
        check({23'h0, tx_word_q}, 32'h0000_01a5);
        chk_irq(2'b00);
        rd(`OFS_STATUS);
        check(got, 32'h0);
    endtask
    task automatic s_rx();
        wr(`OFS_CTRL_ONE, 32'h0000_0023);
        rx_word <= 9'h15a;
        fire(16'h0010);
        settle();
        chk_irq(2'b11);
        rd(`OFS_RX_DATA);
        check(got, 32'h0000_015a);
        settle();
        chk_irq(2'b00);
        fire(16'h0010);
        wr(`OFS_REQUEST, 32'h0000_0008);
        rd(`OFS_STATUS);
        check(got, 32'h0);
    endtask
    task automatic s_queue();
        wr(`OFS_CTRL_ONE, 32'h0);
        wr(`OFS_CTRL_ONE, 32'he000_0003);
        wr(`OFS_CTRL_THREE, 32'h0000_4460);
        rd(`OFS_STATUS);
        check(got, 32'h0003_0000);
        chk_irq(2'b11);
        levels(4'h8, 4'h8, 1'b0);
        fire(16'h0010);
        settle();
        rd(`OFS_STATUS);
        check(got, 32'h003c_0020);
        levels(4'h3, 4'h7, 1'b0);
        rd(`OFS_STATUS);
        check(got, 32'h0029_0020);
        levels(4'h3, 4'h0, 1'b0);
        rd(`OFS_STATUS);
        check(got, 32'h0001_0020);
        rd(`OFS_RX_DATA);
        wr(`OFS_CTRL_THREE, 32'h0);
        levels(4'h3, 4'h8, 1'b1);
        settle();
        settle();
        chk_irq(2'b11);
        rd(`OFS_STATUS);
        check(got, 32'h002d_0000);
        levels(4'h0, 4'h0, 1'b0);
    endtask
    task automatic s_off();
        wr(`OFS_CTRL_ONE, 32'h0000_0003);
        wr(`OFS_CTRL_THREE, 32'h0000_0010);
        fire(16'h4000);
        settle();
        chk_irq(2'b11);
        wr(`OFS_CTRL_ONE, 32'h0);
        settle();
        settle();
        chk_irq(2'b00);
        rd(`OFS_STATUS);
        check(got, 32'h0);
        rd(`OFS_CTRL_THREE);
        check(got, 32'h0000_0010);
        check({31'h0, wake_taken_q != 8'h00}, 32'h1);
        check({31'h0, irq_taken_q != 8'h00}, 32'h1);
    endtask

    // ========
    // verdict, clock, main sequence and watchdog
    task automatic give_verdict();
        if (fails == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial
    begin
        reset = 1'b1;
        address = 8'h00;
        write_data = 32'h0;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        ev = 16'h0;
        tx_queue_count = 4'h0;
        rx_queue_count = 4'h0;
        stop_mode = 1'b0;
        rx_word = 9'h000;
        fails = 0;
        tests_run = 0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        s_regs();
        s_events();
        s_tx();
        s_rx();
        s_queue();
        s_off();
        give_verdict();
    end
    // a hang counts as a mismatch
    initial
    begin
        #200000;
        fails++;
        give_verdict();
    end
endmodule
